// >>> rtl/rng_pkg.sv
// Shared constants, types and mixing functions of the hybrid generator
package rng_pkg;
	localparam int CLK_PERIOD_NS = 5;
	localparam int WORD_W = 16;
	localparam int FIFO_DEPTH = 16;
	// Total failure: run length of equal raw bits that trips the failure
	localparam logic [5:0] RUN_LIMIT = 6'h20;
	// Total failure: longest legal gap between raw bits
	localparam int STARVE_NS = 10000;
	localparam int STARVE_CYC = STARVE_NS / CLK_PERIOD_NS;
	localparam logic [10:0] STARVE_LIMIT = STARVE_CYC[10:0];
	// Online test window of 256 raw bits, monobit bounds
	localparam logic [7:0] WIN_LAST = 8'hff;
	localparam logic [8:0] MONO_LO = 9'h060;
	localparam logic [8:0] MONO_HI = 9'h0a0;
	// Entropy estimator bounds for the light compression ratio
	localparam logic [8:0] BIAS_LO = 9'h070;
	localparam logic [8:0] BIAS_HI = 9'h090;
	localparam logic [2:0] RATIO_LIGHT = 3'h2;
	localparam logic [2:0] RATIO_HEAVY = 3'h4;
	localparam logic [2:0] BYTE_LAST = 3'h7;
	// Seeding length in source bytes
	localparam logic [3:0] SEED_BYTES = 4'h8;
	// Rate credit in bits
	localparam logic [5:0] CREDIT_BYTE = 6'h08;
	localparam logic [5:0] CREDIT_W8 = 6'h08;
	localparam logic [5:0] CREDIT_W16 = 6'h10;
	localparam logic [5:0] CREDIT_MAX = 6'h20;
	localparam logic [63:0] MIX_K1 = 64'h9e37_79b9_7f4a_7c15;
	localparam logic [63:0] MIX_K2 = 64'hc2b2_ae3d_27d4_eb4f;
	localparam logic [7:0] STEP_TAG = 8'h5a;

	typedef enum logic [1:0] {ST_TEST, ST_SEED, ST_RUN, ST_FAIL} stage_e;

	// State transition: absorb one byte with add-rotate-xor rounds
	function automatic logic [63:0] absorb(input logic [63:0] s, input logic [7:0] b);
		logic [63:0] t;
		t = s ^ {56'h0, b};
		t = t + {t[50:0], t[63:51]};
		t = t ^ {t[36:0], t[63:37]};
		t = t + MIX_K1;
		t = t ^ {t[22:0], t[63:23]};
		return t;
	endfunction

	// Output derivation: one-way fold of the state
	function automatic logic [15:0] squeeze(input logic [63:0] s);
		logic [63:0] t;
		t = s ^ {s[31:0], s[63:32]};
		t = t + MIX_K2;
		t = t ^ {t[40:0], t[63:41]};
		return t[15:0] ^ t[47:32];
	endfunction
endpackage

// >>> rtl/word_fifo.sv
// Parameterised word FIFO with valid/ready on both sides and flush
`timescale 1ns/1ps
module word_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic flush,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] FULL = DEPTH[CW-1:0];
	localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wr;
		logic [AW-1:0] rd;
		logic [CW-1:0] cnt;
	} fifo_s;

	fifo_s r_ff;
	fifo_s nxt_r;
	logic push;
	logic pop;

	assign in_ready = r_ff.cnt != FULL;
	assign out_valid = r_ff.cnt != '0;
	assign out_data = r_ff.mem[r_ff.rd];

	always_comb begin
		nxt_r = r_ff;
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		if (push) begin
			nxt_r.mem[r_ff.wr] = in_data;
			nxt_r.wr = (r_ff.wr == LAST) ? '0 : r_ff.wr + 1'b1;
		end
		if (pop) begin
			nxt_r.rd = (r_ff.rd == LAST) ? '0 : r_ff.rd + 1'b1;
		end
		if (push && !pop) begin
			nxt_r.cnt = r_ff.cnt + 1'b1;
		end else if (pop && !push) begin
			nxt_r.cnt = r_ff.cnt - 1'b1;
		end
		// Flush drops every stored word at once
		if (flush) begin
			nxt_r.wr = '0;
			nxt_r.rd = '0;
			nxt_r.cnt = '0;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			r_ff <= '0;
		end else begin
			r_ff <= nxt_r;
		end
	end
endmodule

// >>> rtl/hybrid_generator.sv
// Hybrid random generator: source tests, compression, post-processing, gating
//
// Functional notes
// - Detect total source failure from start; block
// - Failure mid-run discards all pending words
// - Online statistical test at startup and always
// - Block until tested and seeded, or defect
// - Online test sees every raw bit
// - Output bits never exceed consumed input bits
// - Cryptographic state update and output function
// - Words of eight or sixteen bits
// - Seed and input only from physical source
// - Adaptive compression ratio set by estimator
// - Source bytes carry over 7.976 bits entropy
`timescale 1ns/1ps
module hybrid_generator (
	input wire logic CORE_CLK,
	input wire logic RESETN,
	input wire logic RAW_BIT,
	input wire logic RAW_STROBE,
	input wire logic WORD16_SEL,
	output logic RND_VALID,
	output logic [15:0] RND_DATA,
	input wire logic RND_READY,
	output logic OUTPUT_ENABLED,
	output logic SOURCE_FAIL,
	output logic STAT_DEFECT
);
	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic [1:0] sync1;
		logic [1:0] sync2;
		logic strobe_prev;
		logic run_bit;
		logic [5:0] run_cnt;
		logic [10:0] starve_cnt;
		logic [7:0] win_cnt;
		logic [8:0] ones_cnt;
		logic powerup_ok;
		logic total_fail;
		logic defect;
		logic [2:0] ratio;
		logic [2:0] cmp_cnt;
		logic cmp_acc;
		logic [7:0] byte_sh;
		logic [2:0] byte_cnt;
		rng_pkg::stage_e stage;
		logic [3:0] seed_cnt;
		logic [63:0] pp_state;
		logic [5:0] credit;
		logic gen_valid;
		logic [15:0] gen_word;
		logic out_valid;
		logic [15:0] out_data;
		logic out_en;
	} gen_s;

	gen_s r_ff;
	gen_s nxt_r;
	logic raw_new;
	logic raw_val;
	logic cbit;
	logic byte_done;
	logic [7:0] byte_val;
	logic [5:0] need;
	logic permit;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic fifo_out_ready;
	logic [15:0] fifo_out_data;
	logic fifo_flush;
	logic [8:0] win_ones;

	// ****************************************
	// Output buffer
	// ****************************************
	// Back-pressure stalls word generation; raw testing carries on regardless
	word_fifo #(
		.WIDTH(rng_pkg::WORD_W),
		.DEPTH(rng_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk(CORE_CLK),
		.resetn(RESETN),
		.flush(fifo_flush),
		.in_valid(r_ff.gen_valid),
		.in_ready(fifo_in_ready),
		.in_data(r_ff.gen_word),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(fifo_out_data)
	);

	assign fifo_flush = r_ff.total_fail || r_ff.defect;
	assign fifo_out_ready = permit && (!r_ff.out_valid || RND_READY);

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		nxt_r = r_ff;
		cbit = 1'b0;
		byte_done = 1'b0;
		byte_val = 8'h00;
		win_ones = 9'h000;
		// Pins are asynchronous to the core clock
		nxt_r.sync1 = {RAW_STROBE, RAW_BIT};
		nxt_r.sync2 = r_ff.sync1;
		nxt_r.strobe_prev = r_ff.sync2[1];
		raw_new = r_ff.sync2[1] && !r_ff.strobe_prev;
		raw_val = r_ff.sync2[0];

		// Total failure: stuck level or silent source
		if (raw_new) begin
			nxt_r.starve_cnt = '0;
			nxt_r.run_bit = raw_val;
			if (raw_val == r_ff.run_bit) begin
				if (r_ff.run_cnt != rng_pkg::RUN_LIMIT) begin
					nxt_r.run_cnt = r_ff.run_cnt + 1'b1;
				end
			end else begin
				// Run length includes the bit that starts it
				nxt_r.run_cnt = 6'h01;
			end
			if (raw_val == r_ff.run_bit && r_ff.run_cnt + 1'b1 == rng_pkg::RUN_LIMIT) begin
				nxt_r.total_fail = 1'b1;
			end
		end else if (r_ff.starve_cnt == rng_pkg::STARVE_LIMIT) begin
			nxt_r.total_fail = 1'b1;
		end else begin
			nxt_r.starve_cnt = r_ff.starve_cnt + 1'b1;
		end

		// Online monobit test over every raw bit, window by window
		if (raw_new) begin
			win_ones = r_ff.ones_cnt + {8'h00, raw_val};
			nxt_r.win_cnt = r_ff.win_cnt + 1'b1;
			nxt_r.ones_cnt = win_ones;
			if (r_ff.win_cnt == rng_pkg::WIN_LAST) begin
				nxt_r.ones_cnt = '0;
				if (win_ones < rng_pkg::MONO_LO || win_ones > rng_pkg::MONO_HI) begin
					nxt_r.defect = 1'b1;
				end else begin
					nxt_r.powerup_ok = 1'b1;
				end
				// Estimator: more bias, heavier compression
				if (win_ones >= rng_pkg::BIAS_LO && win_ones <= rng_pkg::BIAS_HI) begin
					nxt_r.ratio = rng_pkg::RATIO_LIGHT;
				end else begin
					nxt_r.ratio = rng_pkg::RATIO_HEAVY;
				end
			end
		end

		// Adaptive compression, ratio raw bits folded per output bit
		// Heavy ratio is the starting point so early bytes keep full entropy
		if (r_ff.ratio == 3'h0) begin
			nxt_r.ratio = rng_pkg::RATIO_HEAVY;
		end
		if (raw_new) begin
			cbit = r_ff.cmp_acc ^ raw_val;
			if (r_ff.cmp_cnt + 1'b1 >= r_ff.ratio) begin
				nxt_r.cmp_cnt = '0;
				nxt_r.cmp_acc = 1'b0;
				nxt_r.byte_sh = {r_ff.byte_sh[6:0], cbit};
				nxt_r.byte_cnt = r_ff.byte_cnt + 1'b1;
				if (r_ff.byte_cnt == rng_pkg::BYTE_LAST) begin
					byte_done = 1'b1;
					byte_val = {r_ff.byte_sh[6:0], cbit};
				end
			end else begin
				nxt_r.cmp_cnt = r_ff.cmp_cnt + 1'b1;
				nxt_r.cmp_acc = cbit;
			end
		end

		// Post-processor: seeded and fed only by source bytes
		if (byte_done && (r_ff.stage == rng_pkg::ST_SEED || r_ff.stage == rng_pkg::ST_RUN)) begin
			nxt_r.pp_state = rng_pkg::absorb(r_ff.pp_state, byte_val);
		end
		case (r_ff.stage)
			rng_pkg::ST_TEST: begin
				if (r_ff.powerup_ok) begin
					nxt_r.stage = rng_pkg::ST_SEED;
				end
			end
			rng_pkg::ST_SEED: begin
				if (byte_done) begin
					nxt_r.seed_cnt = r_ff.seed_cnt + 1'b1;
					if (r_ff.seed_cnt + 1'b1 == rng_pkg::SEED_BYTES) begin
						nxt_r.stage = rng_pkg::ST_RUN;
					end
				end
			end
			rng_pkg::ST_RUN: begin
				if (byte_done && r_ff.credit < rng_pkg::CREDIT_MAX) begin
					nxt_r.credit = r_ff.credit + rng_pkg::CREDIT_BYTE;
				end
			end
			rng_pkg::ST_FAIL: begin
				nxt_r.credit = '0;
			end
			default: begin
				nxt_r.stage = rng_pkg::ST_FAIL;
			end
		endcase

		// Word generation spends credit; a stalled word stays pending
		need = WORD16_SEL ? rng_pkg::CREDIT_W16 : rng_pkg::CREDIT_W8;
		if (r_ff.gen_valid && fifo_in_ready) begin
			nxt_r.gen_valid = 1'b0;
		end
		if (r_ff.stage == rng_pkg::ST_RUN && !nxt_r.gen_valid && nxt_r.credit >= need) begin
			nxt_r.credit = nxt_r.credit - need;
			nxt_r.gen_valid = 1'b1;
			nxt_r.gen_word = rng_pkg::squeeze(nxt_r.pp_state);
			if (!WORD16_SEL) begin
				nxt_r.gen_word[15:8] = 8'h00;
			end
			// Step after each word so earlier words cannot be recomputed
			nxt_r.pp_state = rng_pkg::absorb(nxt_r.pp_state, rng_pkg::STEP_TAG);
		end

		// Output stage; consumer takes a word on valid and ready
		if (r_ff.out_valid && RND_READY) begin
			nxt_r.out_valid = 1'b0;
		end
		if (fifo_out_valid && fifo_out_ready) begin
			nxt_r.out_valid = 1'b1;
			nxt_r.out_data = fifo_out_data;
		end

		// Any failure kills everything pending; detection of a stuck level lags its onset by the run limit
		if (nxt_r.total_fail || nxt_r.defect) begin
			nxt_r.stage = rng_pkg::ST_FAIL;
			nxt_r.gen_valid = 1'b0;
			nxt_r.out_valid = 1'b0;
			nxt_r.credit = '0;
		end
		// Registered copy keeps the pin glitch free
		nxt_r.out_en = nxt_r.stage == rng_pkg::ST_RUN;
	end

	assign permit = r_ff.stage == rng_pkg::ST_RUN && !r_ff.total_fail && !r_ff.defect;

	always_ff @(posedge CORE_CLK) begin
		if (!RESETN) begin
			r_ff <= '0;
		end else begin
			r_ff <= nxt_r;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign RND_VALID = r_ff.out_valid;
	assign RND_DATA = r_ff.out_data;
	assign OUTPUT_ENABLED = r_ff.out_en;
	assign SOURCE_FAIL = r_ff.total_fail;
	assign STAT_DEFECT = r_ff.defect;
endmodule

// >>> test/rnd_consumer.sv
// Consumer model that takes random words with random and forced stalls
`timescale 1ns/1ps
module rnd_consumer (
	input wire logic clk,
	input wire logic stall,
	output logic ready
);
	// *****
	// Backpressure
	// *****
	initial ready = 1'b0;
	// Random gaps keep valid and data waiting across edges
	always @(posedge clk) begin
		#1;
		ready <= !stall && ($urandom % 4 != 0);
	end
endmodule

// >>> test/hybrid_generator_asserts.sv
// Checker for the output gating of the hybrid generator
`timescale 1ns/1ps
module hybrid_generator_chk (
	input wire logic CORE_CLK,
	input wire logic RESETN,
	input wire logic RAW_STROBE,
	input wire logic WORD16_SEL,
	input wire logic RND_VALID,
	input wire logic [15:0] RND_DATA,
	input wire logic RND_READY,
	input wire logic OUTPUT_ENABLED,
	input wire logic SOURCE_FAIL,
	input wire logic STAT_DEFECT
);
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!RESETN);
	logic [11:0] gap_ff;
	logic stb_ff;
	// Gap seen at the pin, so the design's sync delay needs slack
	always_ff @(posedge CORE_CLK) begin
		stb_ff <= RAW_STROBE;
		if (!RESETN || (RAW_STROBE && !stb_ff))
			gap_ff <= 12'h000;
		else if (gap_ff != 12'hfff)
			gap_ff <= gap_ff + 12'h001;
	end
	// *****
	// Assertions
	// *****
	property p_gate; RND_VALID |-> OUTPUT_ENABLED; endproperty
	a_gate: assert property (p_gate) else $error("valid while blocked");
	property p_fail; SOURCE_FAIL |-> !RND_VALID && !OUTPUT_ENABLED; endproperty
	a_fail: assert property (p_fail) else $error("output after failure");
	property p_defect; STAT_DEFECT |-> !RND_VALID && !OUTPUT_ENABLED; endproperty
	a_defect: assert property (p_defect) else $error("output after defect");
	property p_stick_fail; SOURCE_FAIL |=> SOURCE_FAIL; endproperty
	a_stick_fail: assert property (p_stick_fail) else $error("failure cleared");
	property p_stick_def; STAT_DEFECT |=> STAT_DEFECT; endproperty
	a_stick_def: assert property (p_stick_def) else $error("defect cleared");
	property p_hold;
		RND_VALID && !RND_READY |=> (RND_VALID && $stable(RND_DATA)) || SOURCE_FAIL || STAT_DEFECT;
	endproperty
	a_hold: assert property (p_hold) else $error("word not held");
	property p_byte; RND_VALID && !WORD16_SEL |-> RND_DATA[15:8] == 8'h00; endproperty
	a_byte: assert property (p_byte) else $error("byte word upper half");
	property p_starve; gap_ff > 12'h7e4 |-> SOURCE_FAIL; endproperty
	a_starve: assert property (p_starve) else $error("starved source unseen");
endmodule
bind hybrid_generator hybrid_generator_chk u_chk (
	.CORE_CLK(CORE_CLK), .RESETN(RESETN), .RAW_STROBE(RAW_STROBE),
	.WORD16_SEL(WORD16_SEL), .RND_VALID(RND_VALID), .RND_DATA(RND_DATA),
	.RND_READY(RND_READY), .OUTPUT_ENABLED(OUTPUT_ENABLED),
	.SOURCE_FAIL(SOURCE_FAIL), .STAT_DEFECT(STAT_DEFECT)
);

// >>> test/tb.sv
// Testbench of the hybrid generator against a counting model
`timescale 1ns/1ps
module tb;
	logic CORE_CLK, RESETN, RAW_BIT, RAW_STROBE, WORD16_SEL, RND_VALID, RND_READY;
	logic [15:0] RND_DATA;
	logic OUTPUT_ENABLED, SOURCE_FAIL, STAT_DEFECT, stall, last, exp_fail, exp_def;
	int errors = 0;
	int num_checks = 0;
	int raw, ones, run, taken;
	hybrid_generator u_hybrid_generator (.CORE_CLK(CORE_CLK), .RESETN(RESETN),
		.RAW_BIT(RAW_BIT), .RAW_STROBE(RAW_STROBE), .WORD16_SEL(WORD16_SEL),
		.RND_VALID(RND_VALID), .RND_DATA(RND_DATA), .RND_READY(RND_READY),
		.OUTPUT_ENABLED(OUTPUT_ENABLED), .SOURCE_FAIL(SOURCE_FAIL), .STAT_DEFECT(STAT_DEFECT));
	rnd_consumer u_rnd_consumer (.clk(CORE_CLK), .stall(stall), .ready(RND_READY));
	initial begin
		CORE_CLK = 1'b0;
		forever #2.5 CORE_CLK = ~CORE_CLK;
	end
	task automatic results();
		if (errors == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic got, input logic exp);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("BAD %0t %h %h", $time, got, exp);
		end
	endtask
	task automatic reset_dut(input logic mode);
		RESETN = 1'b0;
		WORD16_SEL = mode;
		repeat (20) @(posedge CORE_CLK);
		#1 RESETN = 1'b1;
		raw = 0;
		ones = 0;
		taken = 0;
		exp_fail = 1'b0;
		exp_def = 1'b0;
		chk(RND_VALID || OUTPUT_ENABLED || SOURCE_FAIL || STAT_DEFECT, 1'b0);
	endtask
	// Bit held three clocks each side of the strobe edge
	task automatic send(input logic b);
		RAW_BIT = b;
		repeat (3) @(posedge CORE_CLK);
		#1 RAW_STROBE = 1'b1;
		repeat (3) @(posedge CORE_CLK);
		#1 RAW_STROBE = 1'b0;
		repeat (2) @(posedge CORE_CLK);
		#1;
		run = (raw > 0 && b === last) ? run + 1 : 1;
		raw++;
		ones += b;
		last = b;
		if (run >= 32)
			exp_fail = 1'b1;
		if (raw % 256 == 0) begin
			if (ones < 96 || ones > 160)
				exp_def = 1'b1;
			ones = 0;
		end
		chk(SOURCE_FAIL, exp_fail);
		chk(STAT_DEFECT, exp_def);
	endtask
	always @(posedge CORE_CLK) begin
		if (RESETN === 1'b1 && RND_VALID === 1'b1 && RND_READY === 1'b1) begin
			taken += WORD16_SEL ? 16 : 8;
			// Window of 256, 8 seed bytes and one credit byte at ratio 2 at best
			chk(raw >= 400, 1'b1);
			chk(taken * 2 <= raw - 384, 1'b1);
			chk(WORD16_SEL || RND_DATA[15:8] == 8'h00, 1'b1);
		end
	end
	initial begin
		#200us;
		errors++;
		results();
	end
	// *****
	// Stimulus
	// *****
	initial begin
		RAW_BIT = 1'b0;
		RAW_STROBE = 1'b0;
		stall = 1'b0;
		void'($urandom(30));
		for (int m = 0; m < 2; m++) begin
			reset_dut(m[0]);
			// Long stall holds ready low so words queue in the FIFO
			for (int i = 0; i < 800; i++) begin
				stall = (i >= 400 && i < 700);
				send(1'($urandom % 2));
			end
			chk(OUTPUT_ENABLED, !exp_fail && !exp_def);
			chk(taken > 0, !exp_fail && !exp_def);
			for (int i = 0; i < 40; i++)
				send(1'b1);
			chk(RND_VALID || OUTPUT_ENABLED, 1'b0);
		end
		reset_dut(1'b0);
		for (int i = 0; i < 260; i++)
			send(i % 4 == 0);
		chk(OUTPUT_ENABLED, 1'b0);
		reset_dut(1'b1);
		repeat (1900) @(posedge CORE_CLK);
		#1;
		chk(SOURCE_FAIL, 1'b0);
		repeat (200) @(posedge CORE_CLK);
		#1;
		chk(SOURCE_FAIL, 1'b1);
		results();
	end
endmodule
